// [logic/card_param_xfer.sv]
// sequencer moving parameter sets between EEPROM and the memory card
//
// The APB register port and the address map are this design's own decisions.
`default_nettype none
module card_param_xfer
    import card_xfer_pkg::*;
#(
    parameter int unsigned FLASH_CYCLES = FLASH_HALF_CYC
)
(
    input  wire logic        pclk,          // 40 MHz clock
    input  wire logic        presetn,       // async reset, active low
    input  wire logic        psel,          // apb select
    input  wire logic        penable,       // apb access phase
    input  wire logic        pwrite,        // apb direction
    input  wire logic [7:0]  paddr,         // apb byte address
    input  wire logic [31:0] pwdata,        // apb write data
    output var  logic [31:0] prdata,        // apb read data
    output var  logic        pready,        // apb ready
    output var  logic        pslverr,       // apb error, unmapped address
    input  wire logic        card_present,  // card detect pin
    input  wire logic [1:0]  card_fs,       // card file system type
    input  wire logic        card_file_ok,  // file xfer_req.file exists
    output var  xfer_req_t   xfer_req,      // request to transfer engine
    input  wire xfer_rsp_t   xfer_rsp,      // answer from transfer engine
    input  wire logic        ctrl_fault,    // control unit fault state
    input  wire logic        cmd_valid,     // operating command offered
    output var  logic        cmd_accept,    // operating command taken
    output var  led_t        leds           // ready and fault LEDs
);

    typedef struct packed {
        state_t              st;
        logic [2:0]          wait_cnt;
        logic                auto_dl;
        logic [15:0]         pend_flt;
        logic [6:0]          mode;
        logic [6:0]          clone;
        logic [1:0]          upctl;
        logic [1:0]          dnctl;
        logic [1:0]          policy;
        logic [15:0]         fault;
        logic                alarm;
        logic [15:0]         reject;
        logic [2:0]          card_sync;
        logic                card;
        logic [FLASH_W-1:0]  flash_cnt;
        logic                flash_ph;
        xfer_req_t           req;
        led_t                led;
        logic                cmd_ok;
        logic                pready;
        logic                pslverr;
        logic [31:0]         prdata;
    } regs_t;

    regs_t s_q;
    regs_t s_d;

    function automatic mode_class_t mode_class(input logic [6:0] m);
        unique case (m)
            MODE_READY:    mode_class = MC_READY;
            MODE_QUICK:    mode_class = MC_QUICK;
            MODE_INVERTER: mode_class = MC_INVERTER;
            MODE_TRANSFER: mode_class = MC_TRANSFER;
            MODE_SAFETY:   mode_class = MC_SAFETY;
            default:       mode_class = MC_OTHER;
        endcase
    endfunction

    function automatic logic [15:0] dl_fault(input xfer_err_t e);
        unique case (e)
            ERR_NO_CARD:  dl_fault = FLT_NO_CARD;
            ERR_INVALID:  dl_fault = FLT_INVALID;
            ERR_INCOMPAT: dl_fault = FLT_INCOMPAT;
            default:      dl_fault = FLT_EEPROM;
        endcase
    endfunction

    function automatic logic map_ok(input logic [7:0] a);
        map_ok = (a == OFS_MODE) || (a == OFS_CLONE) || (a == OFS_UPCTL)
            || (a == OFS_DNCTL) || (a == OFS_POLICY) || (a == OFS_STATUS)
            || (a == OFS_REJECT);
    endfunction

    logic busy;
    logic card_ok;
    logic wr;
    logic faulted;
    assign busy    = s_q.st != ST_IDLE;
    // a FAT32 or NTFS card is unusable; download faults it as invalid, upload as no card
    assign card_ok = s_q.card && (card_fs == FS_FAT);
    assign wr      = psel && penable && pwrite && s_q.pready && !s_q.pslverr;
    assign faulted = (s_q.fault != FLT_NONE) || ctrl_fault;

    always_comb
    begin
        s_d = s_q;
        s_d.pready  = 1'b0;
        s_d.pslverr = 1'b0;

        // card detect: three stages, a change counts when the last two agree
        s_d.card_sync = {s_q.card_sync[1:0], card_present};
        if (s_q.card_sync[1] == s_q.card_sync[2])
        begin
            s_d.card = s_q.card_sync[2];
        end

        if (s_q.flash_cnt == FLASH_W'(FLASH_CYCLES - 1))
        begin
            s_d.flash_cnt = '0;
            s_d.flash_ph  = !s_q.flash_ph;
        end
        else
        begin
            s_d.flash_cnt = s_q.flash_cnt + 1'b1;
        end

        // read data is captured in the setup phase, so no wait states
        if (psel && !penable)
        begin
            s_d.pready  = 1'b1;
            s_d.pslverr = !map_ok(paddr);
            s_d.prdata  = '0;
            unique case (paddr)
                OFS_MODE:   s_d.prdata[6:0] = s_q.mode;
                OFS_CLONE:  s_d.prdata[6:0] = s_q.clone;
                OFS_UPCTL:  s_d.prdata[1:0] = s_q.upctl;
                OFS_DNCTL:  s_d.prdata[1:0] = s_q.dnctl;
                OFS_POLICY: s_d.prdata[1:0] = s_q.policy;
                OFS_STATUS: s_d.prdata = {s_q.alarm ? ALARM_NO_AUTO : 16'h0000,
                    s_q.fault};
                OFS_REJECT: s_d.prdata[15:0] = s_q.reject;
                default:    s_d.prdata = '0;
            endcase
        end

        if (wr)
        begin
            unique case (paddr)
                OFS_MODE:
                begin
                    if (!busy)
                    begin
                        s_d.mode = pwdata[6:0];
                    end
                end
                OFS_CLONE:
                begin
                    if (!busy && pwdata[31:7] == '0
                        && pwdata[6:0] <= CLONE_MAX)
                    begin
                        s_d.clone = pwdata[6:0];
                    end
                end
                OFS_UPCTL:
                begin
                    if (!busy && pwdata[31:2] == '0 && pwdata[1:0] <= CTL_CARD)
                    begin
                        s_d.upctl = pwdata[1:0];
                    end
                end
                OFS_DNCTL:
                begin
                    // writes while busy are dropped, so no abort is possible
                    if (!busy && pwdata[31:2] == '0 && pwdata[1:0] <= CTL_CARD)
                    begin
                        s_d.dnctl = pwdata[1:0];
                    end
                end
                OFS_POLICY:
                begin
                    if (pwdata[31:2] == '0 && pwdata[1:0] <= POL_ALWAYS)
                    begin
                        s_d.policy = pwdata[1:0];
                    end
                end
                OFS_STATUS:
                begin
                    if (pwdata[0])
                    begin
                        s_d.fault = FLT_NONE;
                    end
                    if (pwdata[1])
                    begin
                        s_d.alarm = 1'b0;
                    end
                end
                default:
                begin
                end
            endcase
        end

        // events come after the software clears so that a set wins
        if (s_d.card && !s_q.card && s_q.st != ST_BOOT
            && s_q.policy == POL_INHIBIT)
        begin
            s_d.alarm = 1'b1;
        end

        s_d.cmd_ok = cmd_valid
            && !(s_q.st inside {ST_DOWNLOAD, ST_RESTORE});

        unique case (s_q.st)
            ST_BOOT:
            begin
                // give the card detect time to settle before deciding
                if (s_q.wait_cnt != BOOT_WAIT)
                begin
                    s_d.wait_cnt = s_q.wait_cnt + 1'b1;
                end
                else if (s_q.policy != POL_INHIBIT && card_ok
                    && card_file_ok)
                begin
                    s_d.st      = ST_DOWNLOAD;
                    s_d.auto_dl = 1'b1;
                    s_d.req     = '{1'b1, OP_DOWNLOAD, 7'h00, 1'b1};
                end
                else
                begin
                    s_d.st = ST_IDLE;
                end
            end
            ST_IDLE:
            begin
                if (mode_class(s_q.mode) == MC_TRANSFER)
                begin
                    if (s_q.upctl == CTL_CARD)
                    begin
                        if (card_ok)
                        begin
                            s_d.st  = ST_SAVE;
                            s_d.req = '{1'b1, OP_SAVE, s_q.clone, 1'b0};
                        end
                        else
                        begin
                            s_d.fault = FLT_NO_CARD;
                            s_d.upctl = CTL_OFF;
                        end
                    end
                    else if (s_q.dnctl == CTL_CARD)
                    begin
                        if (!s_q.card)
                        begin
                            s_d.fault = FLT_NO_CARD;
                            s_d.dnctl = CTL_OFF;
                        end
                        else if (!card_ok)
                        begin
                            s_d.fault = FLT_INVALID;
                            s_d.dnctl = CTL_OFF;
                        end
                        else
                        begin
                            s_d.st  = ST_DOWNLOAD;
                            s_d.req = '{1'b1, OP_DOWNLOAD, s_q.clone, 1'b0};
                        end
                    end
                end
            end
            ST_SAVE:
            begin
                if (xfer_rsp.done)
                begin
                    if (xfer_rsp.err == ERR_NONE)
                    begin
                        s_d.st     = ST_UPLOAD;
                        s_d.req.op = OP_UPLOAD;
                    end
                    else
                    begin
                        s_d.st        = ST_IDLE;
                        s_d.req.valid = 1'b0;
                        s_d.fault     = FLT_EEPROM;
                        s_d.upctl     = CTL_OFF;
                    end
                end
            end
            ST_UPLOAD:
            begin
                if (xfer_rsp.done)
                begin
                    s_d.st        = ST_IDLE;
                    s_d.req.valid = 1'b0;
                    s_d.upctl     = CTL_OFF;
                    if (xfer_rsp.err == ERR_NONE)
                    begin
                        s_d.mode = MODE_READY;
                    end
                    else
                    begin
                        s_d.fault = (xfer_rsp.err == ERR_NO_CARD)
                            ? FLT_NO_CARD : FLT_EEPROM;
                    end
                end
            end
            ST_DOWNLOAD:
            begin
                if (xfer_rsp.done)
                begin
                    if (xfer_rsp.err == ERR_NONE)
                    begin
                        s_d.st        = ST_IDLE;
                        s_d.req.valid = 1'b0;
                        s_d.auto_dl   = 1'b0;
                        if (s_q.auto_dl)
                        begin
                            if (s_q.policy == POL_ONCE)
                            begin
                                s_d.policy = POL_INHIBIT;
                            end
                        end
                        else
                        begin
                            s_d.mode  = MODE_READY;
                            s_d.dnctl = CTL_OFF;
                        end
                    end
                    else
                    begin
                        s_d.st       = ST_RESTORE;
                        s_d.req.op   = OP_RESTORE;
                        s_d.pend_flt = dl_fault(xfer_rsp.err);
                        if (xfer_rsp.err == ERR_INCOMPAT)
                        begin
                            s_d.reject = xfer_rsp.reject;
                        end
                    end
                end
            end
            ST_RESTORE:
            begin
                if (xfer_rsp.done)
                begin
                    s_d.st        = ST_IDLE;
                    s_d.req.valid = 1'b0;
                    s_d.auto_dl   = 1'b0;
                    s_d.dnctl     = CTL_OFF;
                    s_d.fault     = (xfer_rsp.err == ERR_NONE)
                        ? s_q.pend_flt : FLT_EEPROM;
                end
            end
        endcase

        // a fault outranks the upload flashing pattern
        if (faulted)
        begin
            s_d.led = '{1'b0, 1'b1};
        end
        else if (s_q.st inside {ST_SAVE, ST_UPLOAD})
        begin
            s_d.led = '{s_q.flash_ph, !s_q.flash_ph};
        end
        else
        begin
            s_d.led = '{s_q.st == ST_IDLE, 1'b0};
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q        <= '0;
            s_q.st     <= ST_BOOT;
            s_q.clone  <= CLONE_RST;
            s_q.policy <= POL_ONCE;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign prdata     = s_q.prdata;
    assign pready     = s_q.pready;
    assign pslverr    = s_q.pslverr;
    assign xfer_req   = s_q.req;
    assign cmd_accept = s_q.cmd_ok;
    assign leds       = s_q.led;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_alarm_on_insert: assert property (
        $rose(s_q.card) && $past(s_q.policy) == POL_INHIBIT
        && $past(s_q.st) != ST_BOOT |-> s_q.alarm)
        else $error("insert with policy zero did not raise alarm");
    a_fault_led_on: assert property (
        faulted |=> leds.fault && !leds.ready)
        else $error("fault state not shown on leds");
    a_upload_flash: assert property (
        s_q.st == ST_UPLOAD && !faulted |=> leds.ready == $past(s_q.flash_ph)
        && leds.fault != leds.ready)
        else $error("leds not flashing during upload");
    a_save_before_up: assert property (
        $rose(s_q.st == ST_UPLOAD) |-> $past(s_q.st) == ST_SAVE)
        else $error("upload started without saving to eeprom");
    a_clone_in_range: assert property (
        s_q.clone <= CLONE_MAX)
        else $error("clone index beyond 99");
    a_upload_done_clear: assert property (
        s_q.st == ST_UPLOAD && xfer_rsp.done && xfer_rsp.err == ERR_NONE
        |=> s_q.mode == MODE_READY && s_q.upctl == CTL_OFF
        ##1 leds.ready || $past(faulted))
        else $error("upload success did not clear controls");
    a_dl_blocks_cmds: assert property (
        s_q.st == ST_DOWNLOAD |=> !cmd_accept)
        else $error("command accepted during download");
    a_dl_no_abort: assert property (
        s_q.st == ST_DOWNLOAD && !xfer_rsp.done
        |=> s_q.st == ST_DOWNLOAD && xfer_req.valid)
        else $error("download left without completion");
    a_dl_fail_restore: assert property (
        s_q.st == ST_DOWNLOAD && xfer_rsp.done && xfer_rsp.err != ERR_NONE
        |=> s_q.st == ST_RESTORE && xfer_req.op == OP_RESTORE)
        else $error("failed download did not restore eeprom");
    a_reject_kept: assert property (
        s_q.st == ST_DOWNLOAD && xfer_rsp.done && xfer_rsp.err == ERR_INCOMPAT
        |=> s_q.reject == $past(xfer_rsp.reject))
        else $error("first rejected parameter not recorded");
    a_policy_once: assert property (
        s_q.st == ST_DOWNLOAD && s_q.auto_dl && s_q.policy == POL_ONCE
        && xfer_rsp.done && xfer_rsp.err == ERR_NONE
        && !$past(wr) |=> s_q.policy == POL_INHIBIT)
        else $error("policy once not cleared after download");

    c_upload_ok: cover property (
        s_q.st == ST_UPLOAD && xfer_rsp.done && xfer_rsp.err == ERR_NONE);
    c_download_restore: cover property (s_q.st == ST_RESTORE && xfer_rsp.done);
    c_auto_download: cover property (s_q.st == ST_DOWNLOAD && s_q.auto_dl);

endmodule
`default_nettype wire

// [logic/card_xfer_pkg.sv]
// constants and types for the card parameter transfer sequencer
// Notes on behaviour
// - only a plain FAT card is usable; FAT32 or NTFS give invalid fault on download, card-missing on upload
// - card inserted while policy is zero raises the no-auto-download alarm
// - policy zero skips the automatic download at start-up
// - status LEDs flash while an upload to the card runs
// - control unit fault: fault LED on, ready LED off
// - mode selector: 0 ready, 1 quick, 2 inverter, 30 transfer, 95 safety
// - clone file index runs 0 to 99, one file per value
// - working parameters are saved from RAM to EEPROM before any upload
// - upload control: 0 off, 1 panel transfer, 2 EEPROM to card
// - upload success clears mode selector and upload control, ready LED on
// - upload failure raises card-missing or EEPROM fault, fault LED on
// - download control: 0 off, 1 from panel, 2 card into EEPROM
// - operating commands are ignored while a download runs
// - a running download cannot be aborted
// - unloadable contents raise incompatible fault, record first rejected
// - failed download restores the set previously held in EEPROM
// - download success clears mode and download control, ready LED on
// - download failure raises one of four faults, fault LED on
// - automatic download loads all parameters including fail-safe ones
// - policy: 0 inhibit, 1 once (default, then cleared), 2 every start-up
// - automatic download uses clone file zero, skipped when it is absent
`default_nettype none
package card_xfer_pkg;
    localparam int unsigned CLK_HZ         = 40_000_000;
    localparam int unsigned FLASH_HALF_MS  = 250;
    localparam int unsigned FLASH_HALF_CYC = CLK_HZ / 1000 * FLASH_HALF_MS;
    localparam int          FLASH_W        = 24;
    localparam logic [2:0]  BOOT_WAIT      = 3'h6;

    localparam logic [7:0] OFS_MODE   = 8'h00;
    localparam logic [7:0] OFS_CLONE  = 8'h04;
    localparam logic [7:0] OFS_UPCTL  = 8'h08;
    localparam logic [7:0] OFS_DNCTL  = 8'h0c;
    localparam logic [7:0] OFS_POLICY = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_REJECT = 8'h18;

    localparam logic [6:0] MODE_READY    = 7'h00;
    localparam logic [6:0] MODE_QUICK    = 7'h01;
    localparam logic [6:0] MODE_INVERTER = 7'h02;
    localparam logic [6:0] MODE_TRANSFER = 7'h1e;
    localparam logic [6:0] MODE_SAFETY   = 7'h5f;
    localparam logic [6:0] CLONE_RST     = 7'h00;
    localparam logic [6:0] CLONE_MAX     = 7'h63;
    localparam logic [1:0] CTL_OFF       = 2'h0;
    localparam logic [1:0] CTL_PANEL     = 2'h1;
    localparam logic [1:0] CTL_CARD      = 2'h2;
    localparam logic [1:0] POL_INHIBIT   = 2'h0;
    localparam logic [1:0] POL_ONCE      = 2'h1;
    localparam logic [1:0] POL_ALWAYS    = 2'h2;
    localparam logic [1:0] FS_FAT        = 2'h1;

    localparam logic [15:0] FLT_NONE      = 16'h0000;
    localparam logic [15:0] FLT_EEPROM    = 16'h0033;
    localparam logic [15:0] FLT_NO_CARD   = 16'h003d;
    localparam logic [15:0] FLT_INVALID   = 16'h003e;
    localparam logic [15:0] FLT_INCOMPAT  = 16'h003f;
    localparam logic [15:0] ALARM_NO_AUTO = 16'h0234;

    typedef enum logic [1:0] {OP_SAVE, OP_UPLOAD, OP_DOWNLOAD, OP_RESTORE}
        xfer_op_t;
    typedef enum logic [2:0] {ERR_NONE, ERR_EEPROM, ERR_NO_CARD, ERR_INVALID,
        ERR_INCOMPAT} xfer_err_t;
    typedef enum logic [2:0] {MC_READY, MC_QUICK, MC_INVERTER, MC_TRANSFER,
        MC_SAFETY, MC_OTHER} mode_class_t;
    typedef enum logic [2:0] {ST_BOOT, ST_IDLE, ST_SAVE, ST_UPLOAD,
        ST_DOWNLOAD, ST_RESTORE} state_t;

    typedef struct packed {
        logic       valid;
        xfer_op_t   op;
        logic [6:0] file;
        logic       all_params;
    } xfer_req_t;

    typedef struct packed {
        logic        done;
        xfer_err_t   err;
        logic [15:0] reject;
    } xfer_rsp_t;

    typedef struct packed {
        logic ready;
        logic fault;
    } led_t;
endpackage
`default_nettype wire

// [dv/card_model.sv]
// card and transfer engine model facing the sequencer
`default_nettype none
module card_model
    import card_xfer_pkg::*;
(
    input  wire logic       pclk,         // clock
    input  wire logic       presetn,      // reset
    input  wire logic       inserted,     // card in slot
    input  wire xfer_err_t  fail_err,     // download answer
    input  wire logic [1:0] fs_type,      // file system to report
    input  wire xfer_req_t  xfer_req,     // request
    output var  xfer_rsp_t  xfer_rsp,     // answer
    output var  logic       card_present, // detect pin
    output var  logic [1:0] card_fs,      // file system
    output var  logic       card_file_ok  // file exists
);
    logic [3:0] cnt_q;
    logic       hit;
    assign card_present = inserted;
    assign card_fs = fs_type;
    // file 7 never exists; latency grows with the low two bits of the file number
    assign card_file_ok = inserted && (xfer_req.file != 7'h07);
    assign hit = xfer_req.valid && (cnt_q == {xfer_req.file[1:0], 2'h3});
    assign xfer_rsp = '{done: hit, reject: 16'h0123,
        err: (hit && xfer_req.op == OP_DOWNLOAD) ? fail_err : ERR_NONE};
    // restart after each answer, so done never comes twice in a row
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            cnt_q <= 4'h0;
        else
            cnt_q <= (xfer_req.valid && !hit) ? cnt_q + 4'h1 : 4'h0;
endmodule
`default_nettype wire

// [dv/card_param_xfer_test.sv]
// self-checking bench for the card parameter transfer sequencer
`default_nettype none
module card_param_xfer_test;
    timeunit 1ns;
    timeprecision 1ps;
    import card_xfer_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        card_present, card_file_ok, ctrl_fault, cmd_valid;
    logic        cmd_accept, inserted, err_v, ph_v;
    logic [1:0]  card_fs, fs_type;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd_v;
    xfer_req_t   xfer_req;
    xfer_rsp_t   xfer_rsp;
    xfer_err_t   fail_err;
    led_t        leds;
    int          error_cnt = 0;
    int          cmp_count = 0;
    card_param_xfer #(.FLASH_CYCLES(4)) dut_u (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .card_present(card_present), .card_fs(card_fs),
        .card_file_ok(card_file_ok), .xfer_req(xfer_req),
        .xfer_rsp(xfer_rsp), .ctrl_fault(ctrl_fault), .cmd_valid(cmd_valid),
        .cmd_accept(cmd_accept), .leds(leds));
    card_model card_u (.pclk(pclk), .presetn(presetn), .inserted(inserted),
        .fail_err(fail_err), .fs_type(fs_type), .xfer_req(xfer_req),
        .xfer_rsp(xfer_rsp),
        .card_present(card_present), .card_fs(card_fs),
        .card_file_ok(card_file_ok));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd_v = prdata;
        err_v = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd_v, exp);
    endtask
    // the watchdog bounds this wait
    task automatic await(input logic v, input xfer_op_t op);
        while (xfer_req.valid !== v || (v && xfer_req.op !== op))
            @(posedge pclk);
    endtask
    task automatic t_boot;
        repeat (12) @(posedge pclk);
        chk(xfer_req.valid, 32'h0);
        rd(OFS_POLICY, 32'h1);
        apb(1'b0, 8'h1c, 32'h0);
        chk(err_v, 32'h1);
    endtask
    task automatic t_upload;
        inserted <= 1'b1;
        apb(1'b1, OFS_MODE, 32'h1);
        apb(1'b1, OFS_CLONE, 32'h63);
        apb(1'b1, OFS_UPCTL, 32'h2);
        repeat (2) @(posedge pclk);
        chk(xfer_req.valid, 32'h0);
        apb(1'b1, OFS_UPCTL, 32'h1);
        apb(1'b1, OFS_MODE, 32'h1e);
        repeat (2) @(posedge pclk);
        chk(xfer_req.valid, 32'h0);
        apb(1'b1, OFS_UPCTL, 32'h2);
        await(1'b1, OP_SAVE);
        chk(xfer_req.file, 32'h63);
        await(1'b1, OP_UPLOAD);
        chk(leds.ready ^ leds.fault, 32'h1);
        ph_v = leds.ready;
        repeat (4) @(posedge pclk);
        chk(leds.ready, !ph_v);
        await(1'b0, OP_SAVE);
        repeat (2) @(posedge pclk);
        chk(leds, 32'h2);
        rd(OFS_MODE, 32'h0);
        rd(OFS_UPCTL, 32'h0);
    endtask
    task automatic t_download;
        fail_err <= ERR_INCOMPAT;
        apb(1'b1, OFS_CLONE, 32'h2);
        apb(1'b1, OFS_MODE, 32'h1e);
        apb(1'b1, OFS_DNCTL, 32'h2);
        await(1'b1, OP_DOWNLOAD);
        cmd_valid <= 1'b1;
        apb(1'b1, OFS_DNCTL, 32'h0);
        chk(cmd_accept, 32'h0);
        await(1'b1, OP_RESTORE);
        await(1'b0, OP_SAVE);
        @(posedge pclk);
        chk(cmd_accept, 32'h1);
        cmd_valid <= 1'b0;
        rd(OFS_STATUS, 32'h3f);
        rd(OFS_REJECT, 32'h0123);
        chk(leds, 32'h1);
        apb(1'b1, OFS_STATUS, 32'h1);
        fail_err <= ERR_NONE;
        apb(1'b1, OFS_MODE, 32'h1e);
        apb(1'b1, OFS_DNCTL, 32'h2);
        await(1'b1, OP_DOWNLOAD);
        await(1'b0, OP_SAVE);
        repeat (2) @(posedge pclk);
        chk(leds, 32'h2);
        rd(OFS_MODE, 32'h0);
        rd(OFS_DNCTL, 32'h0);
    endtask
    task automatic t_faults;
        inserted <= 1'b0;
        repeat (8) @(posedge pclk);
        apb(1'b1, OFS_MODE, 32'h1e);
        apb(1'b1, OFS_UPCTL, 32'h2);
        rd(OFS_STATUS, 32'h3d);
        chk(leds, 32'h1);
        apb(1'b1, OFS_STATUS, 32'h1);
        apb(1'b1, OFS_POLICY, 32'h0);
        inserted <= 1'b1;
        repeat (8) @(posedge pclk);
        rd(OFS_STATUS, 32'h0234_0000);
        fs_type <= 2'h2;
        apb(1'b1, OFS_DNCTL, 32'h2);
        rd(OFS_STATUS, 32'h0234_003e);
        apb(1'b1, OFS_STATUS, 32'h3);
        fs_type <= FS_FAT;
        ctrl_fault <= 1'b1;
        repeat (2) @(posedge pclk);
        chk(leds, 32'h1);
        ctrl_fault <= 1'b0;
    endtask
    task automatic t_auto;
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        await(1'b1, OP_DOWNLOAD);
        chk({xfer_req.all_params, xfer_req.file}, 32'h80);
        await(1'b0, OP_SAVE);
        rd(OFS_POLICY, 32'h0);
    endtask
    task automatic end_sim;
        $display("compares %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    initial
    begin
        {presetn, psel, penable, pwrite, inserted, ctrl_fault} = 6'h00;
        {paddr, pwdata, cmd_valid} = 41'h0;
        fail_err = ERR_NONE;
        fs_type = FS_FAT;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_boot;
        t_upload;
        t_download;
        t_faults;
        t_auto;
        end_sim;
    end
    initial
    begin
        repeat (3000) @(posedge pclk);
        error_cnt++;
        end_sim;
    end
endmodule
`default_nettype wire
